// *** logic/btd_pkg.sv ***
// Package for the biphase/tach decoder: field widths, modes and carrier structs
package btd_pkg;

  // ==========================================================================
  // Widths and reset values
  localparam int PULSE_W = 16;
  localparam int FRAME_W = 24;
  localparam logic [PULSE_W-1:0] PULSES_PER_FRAME_RST = 16'h0064;
  localparam logic [FRAME_W-1:0] FRAME_RST = 24'h000000;
  localparam logic [PULSE_W-1:0] PULSE_RST = 16'h0000;

  // ==========================================================================
  // Edge decode states (one-hot)
  typedef enum logic [2:0] {
    BTD_IDLE = 3'b001,
    BTD_FWD  = 3'b010,
    BTD_REV  = 3'b100
  } btd_step_t;

  // Configuration carried as one bundle
  typedef struct packed {
    logic tach_mode;       // 1: A is rate, B is direction level
    logic fwd_b_leads;     // Quadrature: 1 means B leading A is forward
    logic tach_fwd_high;   // Tach: 1 means B high is forward
    logic pos_ref;         // 1: direction drives the position count
    logic [PULSE_W-1:0] pulses_per_frame;
  } btd_cfg_t;

  // Decoded position bundle
  typedef struct packed {
    logic [FRAME_W-1:0] frame;
    logic [PULSE_W-1:0] pulse;
  } btd_pos_t;

endpackage

// *** logic/btd_decoder.sv ***
// Biphase/tach decoder: direction, clock reference pulse and frame position
`timescale 1ns/10ps
// What this block does
// - Quadrature mode: direction comes from which of two quarter-offset waves rises first.
// - Polarity setting chooses whether A leading or B leading means forward.
// - Tach mode: A is the rate wave, B a steady direction level.
// - Tach polarity setting chooses whether B low or B high means forward.
// - In tach mode only rising edges of A form the clock reference.
// - Direction affects position only when selected as positional reference.
// - Pulses per frame is configurable to match the encoder.
// - Position starts from a loaded frame address and follows pulses and direction.
// - Any speed including standstill is tolerated; state holds between edges.
module btd_decoder
  import btd_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Encoder waves
  input wire logic wave_a,
  input wire logic wave_b,
  // Configuration
  input wire btd_cfg_t cfg,
  // Start frame load
  input wire logic load_en,
  input wire logic [FRAME_W-1:0] load_frame,
  // Results
  output btd_pos_t pos,
  output logic dir_fwd,
  output logic ref_pulse
);

  // ==========================================================================
  // Input history
  logic a_r;
  logic b_r;
  btd_step_t step_nxt;
  logic quad_fwd;
  logic tach_fwd;
  logic fwd_nxt;
  logic a_rise;
  logic b_rise;
  btd_pos_t pos_r;
  logic dir_r;
  logic ref_r;

  // Previous wave levels for edge detection; inputs are already synchronous
  always_ff @(posedge core_clk) begin
    if (rst) begin
      // Seeding from the pins keeps a wave already high at release from faking a rise
      a_r <= wave_a;
      b_r <= wave_b;
    end else begin
      a_r <= wave_a;
      b_r <= wave_b;
    end
  end

  assign a_rise = wave_a & ~a_r;
  assign b_rise = wave_b & ~b_r;

  // ==========================================================================
  // Direction decode
  // A rising while B is low means A leads; B rising while A is low means B leads
  // A tie of two rises in one cycle cannot be ordered, so it is dropped, not guessed
  always_comb begin
    step_nxt = BTD_IDLE;
    if (cfg.tach_mode) begin
      if (a_rise) begin
        step_nxt = tach_fwd ? BTD_FWD : BTD_REV;
      end
    end else begin
      case ({a_rise, b_rise})
        2'b10: begin
          step_nxt = (!wave_b ^ cfg.fwd_b_leads) ? BTD_FWD : BTD_REV;
        end
        2'b01: begin
          step_nxt = (!wave_a ^ cfg.fwd_b_leads) ? BTD_REV : BTD_FWD;
        end
        default: begin
          step_nxt = BTD_IDLE; // No edge or ambiguous double edge
        end
      endcase
    end
  end

  // Tach direction level and the decoded step, as plain levels
  assign tach_fwd = (wave_b == cfg.tach_fwd_high);
  assign quad_fwd = (step_nxt == BTD_FWD);
  // Direction level keeps its last value while stopped
  // Holding it lets a stopped or creeping transport resume with the right sense
  assign fwd_nxt = (step_nxt == BTD_IDLE) ? dir_r : quad_fwd;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      dir_r <= 1'b1;
      ref_r <= 1'b0;
    end else begin
      dir_r <= fwd_nxt;
      ref_r <= (step_nxt != BTD_IDLE);
    end
  end

  // ==========================================================================
  // Position counter
  // Clock-only use always counts up, so a jittery direction cannot disturb it
  // A zero pulses_per_frame is not guarded: the count then runs through all 16 bits
  // Results lag the wave edge by one clock; steps may come on every cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pos_r.frame <= FRAME_RST;
      pos_r.pulse <= PULSE_RST;
    end else if (load_en) begin
      pos_r.frame <= load_frame;
      pos_r.pulse <= PULSE_RST;
    end else if (step_nxt != BTD_IDLE) begin
      if (quad_fwd || !cfg.pos_ref) begin
        if (pos_r.pulse >= cfg.pulses_per_frame - 16'h0001) begin
          pos_r.pulse <= PULSE_RST;
          pos_r.frame <= pos_r.frame + 24'h000001;
        end else begin
          pos_r.pulse <= pos_r.pulse + 16'h0001;
        end
      end else begin
        if (pos_r.pulse == PULSE_RST) begin
          pos_r.pulse <= cfg.pulses_per_frame - 16'h0001;
          pos_r.frame <= pos_r.frame - 24'h000001;
        end else begin
          pos_r.pulse <= pos_r.pulse - 16'h0001;
        end
      end
    end
  end

  // Outputs straight from their flip-flops
  assign pos = pos_r;
  assign dir_fwd = dir_r;
  assign ref_pulse = ref_r;

  // ==========================================================================
  // Checks: direction decode
  // Each step is judged one edge later, against the inputs seen at the step
  a_ref_from_edge: assert property (@(posedge core_clk) disable iff (rst)
    ref_pulse |-> $past(cfg.tach_mode ? (wave_a & ~a_r) : ((wave_a ^ a_r) | (wave_b ^ b_r))))
    else $error("reference pulse without an input edge");
  a_tach_dir_pol: assert property (@(posedge core_clk) disable iff (rst)
    (cfg.tach_mode && a_rise) |=> (dir_fwd == $past(wave_b == cfg.tach_fwd_high)))
    else $error("tach direction polarity wrong");
  a_quad_a_lead: assert property (@(posedge core_clk) disable iff (rst)
    (!cfg.tach_mode && a_rise && !b_rise && !wave_b) |=> (dir_fwd == !$past(cfg.fwd_b_leads)))
    else $error("A leading decoded wrongly");
  a_quad_b_lead: assert property (@(posedge core_clk) disable iff (rst)
    (!cfg.tach_mode && b_rise && !a_rise && !wave_a) |=> (dir_fwd == $past(cfg.fwd_b_leads)))
    else $error("B leading decoded wrongly");
  // A rise while the other wave is already high means the other wave led
  a_quad_a_high: assert property (@(posedge core_clk) disable iff (rst)
    (!cfg.tach_mode && a_rise && !b_rise && wave_b) |=> (dir_fwd == $past(cfg.fwd_b_leads)))
    else $error("A rising after B decoded wrongly");
  a_quad_b_high: assert property (@(posedge core_clk) disable iff (rst)
    (!cfg.tach_mode && b_rise && !a_rise && wave_a) |=> (dir_fwd == !$past(cfg.fwd_b_leads)))
    else $error("B rising after A decoded wrongly");
  a_tach_b_ignored: assert property (@(posedge core_clk) disable iff (rst)
    (cfg.tach_mode && !a_rise && !load_en) |=> $stable(pos))
    else $error("position moved without a rate edge");
  a_stop_holds: assert property (@(posedge core_clk) disable iff (rst)
    (wave_a == a_r && wave_b == b_r) |=> $stable(dir_fwd) && !ref_pulse)
    else $error("state changed while stopped");

  // ==========================================================================
  // Checks: reference pulse
  a_ref_on_step: assert property (@(posedge core_clk) disable iff (rst)
    (step_nxt != BTD_IDLE) |=> ref_pulse)
    else $error("decoded step gave no reference pulse");
  a_tach_ref_only: assert property (@(posedge core_clk) disable iff (rst)
    (cfg.tach_mode && !a_rise) |=> !ref_pulse)
    else $error("reference pulse in tach mode without a rate rise");
  a_quad_falls_quiet: assert property (@(posedge core_clk) disable iff (rst)
    (!cfg.tach_mode && !a_rise && !b_rise) |=> (!ref_pulse && $stable(dir_fwd)))
    else $error("falling edge decoded as a step");

  // ==========================================================================
  // Checks: position counter
  // Steps are checked away from a load, which wins when both come in one cycle
  a_load_start: assert property (@(posedge core_clk) disable iff (rst)
    load_en |=> (pos.frame == $past(load_frame) && pos.pulse == PULSE_RST))
    else $error("start frame not loaded");
  a_clock_only_up: assert property (@(posedge core_clk) disable iff (rst)
    (!cfg.pos_ref && !load_en && step_nxt == BTD_REV && pos.pulse + 16'h0001 < cfg.pulses_per_frame)
    |=> pos.pulse == $past(pos.pulse) + 16'h0001)
    else $error("direction used while only clock reference");
  a_wrap_up: assert property (@(posedge core_clk) disable iff (rst)
    (!load_en && quad_fwd && pos.pulse == cfg.pulses_per_frame - 16'h0001)
    |=> (pos.pulse == PULSE_RST && pos.frame == $past(pos.frame) + 24'h000001))
    else $error("frame did not advance on wrap");
  a_wrap_down: assert property (@(posedge core_clk) disable iff (rst)
    (!load_en && cfg.pos_ref && step_nxt == BTD_REV && pos.pulse == PULSE_RST)
    |=> (pos.frame == $past(pos.frame) - 24'h000001))
    else $error("frame did not step back on wrap");
  a_up_step: assert property (@(posedge core_clk) disable iff (rst)
    (!load_en && step_nxt == BTD_FWD && pos.pulse < cfg.pulses_per_frame - 16'h0001)
    |=> (pos.pulse == $past(pos.pulse) + 16'h0001 && $stable(pos.frame)))
    else $error("forward step did not count up");
  a_down_step: assert property (@(posedge core_clk) disable iff (rst)
    (!load_en && cfg.pos_ref && step_nxt == BTD_REV && pos.pulse != PULSE_RST)
    |=> (pos.pulse == $past(pos.pulse) - 16'h0001 && $stable(pos.frame)))
    else $error("reverse step did not count down");
  // A zero count is left out, as it has no range to keep to
  a_pulse_in_range: assert property (@(posedge core_clk) disable iff (rst)
    (!load_en && cfg.pulses_per_frame != 16'h0000 && pos.pulse < cfg.pulses_per_frame)
    |=> (pos.pulse < $past(cfg.pulses_per_frame)))
    else $error("pulse count left its frame range");

  // ==========================================================================
  // Coverage of the main scenarios
  c_fwd_step: cover property (@(posedge core_clk) disable iff (rst) step_nxt == BTD_FWD);
  c_rev_step: cover property (@(posedge core_clk) disable iff (rst) cfg.pos_ref && step_nxt == BTD_REV);
  c_frame_up: cover property (@(posedge core_clk) disable iff (rst) quad_fwd && pos.pulse == cfg.pulses_per_frame - 16'h0001);
  c_tach_edge: cover property (@(posedge core_clk) disable iff (rst) cfg.tach_mode && a_rise);
  c_clock_only: cover property (@(posedge core_clk) disable iff (rst) !cfg.pos_ref && step_nxt == BTD_REV);

endmodule // btd_decoder

// *** sim/btd_encoder.sv ***
// Transport encoder model: quadrature or tach waves stepped on request
`timescale 1ns/10ps
module btd_encoder (
  // Clock, reset and step control
  input wire logic core_clk,
  input wire logic rst,
  input wire logic step,
  input wire logic rev,
  // Mode and tach direction level
  input wire logic tach,
  input wire logic b_level,
  // Waves
  output logic wave_a,
  output logic wave_b
);
  logic [1:0] ph_r;
  // Quarter-cycle phase; reverse walks the same Gray order backwards
  always_ff @(posedge core_clk) begin
    if (rst) ph_r <= 2'h0;
    else if (step) ph_r <= rev ? ph_r - 2'h1 : ph_r + 2'h1;
  end
  // In quadrature A is the XOR of the phase bits and B the high bit; in tach mode A is the low bit and B is the b_level input
  assign wave_a = tach ? ph_r[0] : ph_r[1] ^ ph_r[0];
  assign wave_b = tach ? b_level : ph_r[1];
endmodule // btd_encoder

// *** sim/tb_biphase_tach_decoder.sv ***
// Bench for the decoder: direction table, wraps, loads, standstill
`timescale 1ns/10ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module tb_biphase_tach_decoder
  import btd_pkg::*;
();
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic step = 1'b0, rev = 1'b0, b_level = 1'b0, load_en = 1'b0;
  logic [FRAME_W-1:0] load_frame = 24'h000010;
  logic [FRAME_W-1:0] exp_f = 24'h000010;
  logic [PULSE_W-1:0] exp_p = 16'h0000;
  logic wave_a, wave_b, dir_fwd, ref_pulse;
  btd_cfg_t cfg = '0;
  btd_pos_t pos;
  int mismatches = 0, comparisons = 0, refs = 0, exp_refs = 0, cycles = 0;
  btd_decoder btd_decoder_i (.core_clk(core_clk), .rst(rst), .wave_a(wave_a), .wave_b(wave_b), .cfg(cfg),
    .load_en(load_en), .load_frame(load_frame), .pos(pos), .dir_fwd(dir_fwd), .ref_pulse(ref_pulse));
  btd_encoder btd_encoder_i (.core_clk(core_clk), .rst(rst), .step(step), .rev(rev), .tach(cfg.tach_mode),
    .b_level(b_level), .wave_a(wave_a), .wave_b(wave_b));
  // ====
  // Clock, pulse tally and hang guard
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (ref_pulse === 1'b1) refs++;
    if (cycles == 20000) begin
      mismatches++;
      results();
    end
  end
  // ====
  // Tasks: step the encoder, track the expected count, compare
  task automatic quarters(input int n);
    repeat (n) begin
      step <= 1'b1;
      @(posedge core_clk);
      step <= 1'b0;
      repeat (3) @(posedge core_clk);
    end
  endtask
  task automatic adv(input int n, input logic up);
    repeat (n) begin
      if (up && exp_p == cfg.pulses_per_frame - 16'h0001) begin exp_p = '0; exp_f++; end
      else if (up) exp_p++;
      else if (exp_p == '0) begin exp_p = cfg.pulses_per_frame - 16'h0001; exp_f--; end
      else exp_p--;
    end
    exp_refs += n;
  endtask
  task automatic check_pos();
    repeat (2) @(posedge core_clk);
    `CHK("frame", exp_f, pos.frame)
    `CHK("pulse", exp_p, pos.pulse)
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ====
  // Main sequence
  initial begin
    cfg.pulses_per_frame <= 16'h0003; // Small count so wraps come often
    cfg.pos_ref <= 1'b1;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    `CHK("dir_rst", 1'b1, dir_fwd)
    load_en <= 1'b1;
    @(posedge core_clk);
    load_en <= 1'b0;
    check_pos();
    // Every mode, polarity and direction: forward when order or level matches polarity
    for (int m = 0; m < 8; m++) begin
      cfg.tach_mode <= m[2];
      cfg.fwd_b_leads <= m[1];
      cfg.tach_fwd_high <= m[1];
      rev <= m[0] & ~m[2];
      b_level <= m[0];
      @(posedge core_clk);
      quarters(m[2] ? 6 : 8);
      adv(m[2] ? 3 : 4, m[0] == m[1]);
      check_pos();
      `CHK("dir", m[0] == m[1], dir_fwd)
    end
    // Clock reference only: reverse order must still count up
    cfg.pos_ref <= 1'b0;
    cfg.tach_mode <= 1'b0;
    cfg.fwd_b_leads <= 1'b0;
    rev <= 1'b1;
    quarters(4);
    adv(2, 1'b1);
    check_pos();
    load_frame <= 24'h00abcd;
    load_en <= 1'b1;
    @(posedge core_clk);
    load_en <= 1'b0;
    exp_f = 24'h00abcd;
    exp_p = '0;
    check_pos();
    repeat (200) @(posedge core_clk);
    check_pos();
    quarters(4);
    adv(2, 1'b1);
    check_pos();
    `CHK("refs", exp_refs, refs)
    results();
  end
endmodule // tb_biphase_tach_decoder
